// file: uid_pkg.sv
// Package of offsets, fields, reset values and carriers for the UART interrupt and DMA-ready block
// Contract
// R01: Mask bit 3 enables the modem status interrupt; reset value 0.
// R02: Mask bit 2 enables line status interrupt, raised on each received character.
// R03: Mask bit 1 enables interrupt raised when transmit holding register is empty.
// R04: Mask bit 0 enables receive data interrupt at trigger level, clears below it.
// R05: Source register flags trigger condition; flag and interrupt clear below trigger level.
// R06: Data-ready sets when a character enters receive FIFO; clears only when empty.
// R07: FIFO on and all four mask bits clear gives independent polled operation.
// R08: Line status bits 1 to 4 report the reception error types seen.
// R09: Line status bit 5 shows transmit FIFO empty.
// R10: Line status bit 6 shows transmit FIFO and shift register both empty.
// R11: Line status bit 7 shows any errored character held in receive FIFO.
// R12: DMA mode 0: transmit request low while a transmit slot is free.
// R13: DMA mode 0: receive request low while the receive holding register holds data.
// R14: DMA mode 1: transmit interrupt sets only when transmit FIFO is completely empty.
// R15: DMA mode 1: receive interrupt at trigger level; FIFO keeps filling until full.
// R16: DMA mode 1: receive request stays low while fill exceeds trigger level.
// R17: Enabled receive, transmit, line and modem conditions appear on interrupt output.
// R18: FIFO control bit 0 selects FIFO mode; cleared means single-character holding.
// R19: FIFO control bits 7:6 pick receive trigger level for interrupt and DMA request.
// R20: Interrupt output high while any enabled source pending, low once all cleared.
package uid_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 5;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_DATA = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_MASK = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_FCTL = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_LSTAT = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_MODEM = 3'h6;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int MASK_RXD = 0;
   localparam int MASK_TXE = 1;
   localparam int MASK_LINE = 2;
   localparam int MASK_MODEM = 3;
   localparam int FCTL_EN = 0;
   localparam int FCTL_RXRST = 1;
   localparam int FCTL_TXRST = 2;
   localparam int FCTL_DMA = 3;
   localparam int FCTL_TRIG = 6;
   localparam int LS_DR = 0;
   localparam int LS_ERR = 1;
   localparam int LS_THRE = 5;
   localparam int LS_TEMT = 6;
   localparam int LS_FERR = 7;

   // ----------------------------------------
   // Reset values and source codes
   // ----------------------------------------
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [DATA_W-1:0] FCTL_RST = 8'h00;
   localparam logic [DATA_W-1:0] ISR_RST = 8'h01;
   localparam logic [DATA_W-1:0] LSR_RST = 8'h60;
   localparam logic [2:0] SRC_LINE = 3'h3;
   localparam logic [2:0] SRC_RXD = 3'h2;
   localparam logic [2:0] SRC_TXE = 3'h1;
   localparam logic [2:0] SRC_MODEM = 3'h0;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } uid_bus_s;

   typedef struct packed {
      logic rx_push;
      logic [2:0] rx_char_err;
      logic [DATA_W-1:0] rx_data;
      logic tx_pop;
      logic tx_shift_busy;
      logic modem_change;
      logic [DATA_W-1:0] modem_status;
   } uid_core_s;
endpackage

// file: uid_sticky.sv
// Sticky flags where a set in the clearing cycle wins
module uid_sticky #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Set and clear
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   // State
   output logic [W-1:0] q
);
   logic [W-1:0] q_ff;

   if (W < 1) begin : g_bad
      $error("uid_sticky: W must be at least 1");
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q_ff <= '0;
      end else begin
         q_ff <= set | (q_ff & ~clr);
      end
   end

   assign q = q_ff;
endmodule

// file: uid_fill_cnt.sv
// Fill tracker of a FIFO with one tag bit per entry
module uid_fill_cnt #(
   parameter int DEPTH = 16,
   parameter int CW = 5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control
   input wire logic push,
   input wire logic push_tag,
   input wire logic pop,
   input wire logic flush,
   input wire logic [CW-1:0] limit,
   // Status
   output logic [CW-1:0] count,
   output logic full,
   output logic empty,
   output logic tag_any
);
   localparam int PW = $clog2(DEPTH);

   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] tag_cnt_ff;
   logic [DEPTH-1:0] tag_ff;
   logic do_push;
   logic do_pop;

   if (DEPTH < 2 || (1 << PW) != DEPTH || CW != $clog2(DEPTH + 1)) begin : g_bad
      $error("uid_fill_cnt: DEPTH must be a power of two and CW fit it");
   end

   // Limit narrows the ring to one entry in holding-register mode
   assign full = (cnt_ff >= limit);
   assign empty = (cnt_ff == '0);
   assign do_push = push & ~full;
   assign do_pop = pop & ~empty;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else if (flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tag_ff <= '0;
         tag_cnt_ff <= '0;
      end else if (flush) begin
         tag_cnt_ff <= '0;
      end else begin
         if (do_push) begin
            tag_ff[wr_ptr_ff] <= push_tag;
         end
         tag_cnt_ff <= tag_cnt_ff + CW'(do_push & push_tag) - CW'(do_pop & tag_ff[rd_ptr_ff]);
      end
   end

   assign count = cnt_ff;
   assign tag_any = (tag_cnt_ff != '0);
endmodule

// file: uid_top.sv
// Interrupt enable, line status and DMA-ready signalling of a UART with 16-byte FIFOs
module uid_top #(
   parameter logic [4:0] TRIG_LVL0 = 5'h01,
   parameter logic [4:0] TRIG_LVL1 = 5'h04,
   parameter logic [4:0] TRIG_LVL2 = 5'h08,
   parameter logic [4:0] TRIG_LVL3 = 5'h0e
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register port
   input wire uid_pkg::uid_bus_s bus,
   output logic [uid_pkg::DATA_W-1:0] rd_data,
   // UART core status, same clock
   input wire uid_pkg::uid_core_s core,
   // Towards UART core
   output logic tx_load,
   output logic [uid_pkg::DATA_W-1:0] tx_load_data,
   output logic rx_take,
   // Pins
   output logic irq,
   output logic rx_dma_request_n,
   output logic tx_dma_request_n
);
   import uid_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [3:0] mask_ff;
   logic fifo_en_ff;
   logic dma_mode_ff;
   logic [1:0] trig_sel_ff;
   logic [DATA_W-1:0] rd_data_ff;
   logic irq_ff;
   logic rx_req_n_ff;
   logic tx_req_n_ff;
   logic rx_hold_ff, tx_go_ff, tx_cond_ff;
   logic tx_load_ff;
   logic [DATA_W-1:0] tx_data_ff;
   logic rx_take_ff;
   logic wr_data, rd_data_reg, wr_mask, wr_fctl, rd_fctl, rd_lstat, rd_modem;
   logic mode1;
   logic rx_flush, tx_flush;
   logic [CNT_W-1:0] limit, trig, rx_cnt, tx_cnt;
   logic rx_full, rx_empty, tx_full, tx_empty;
   logic rx_err_any;
   logic rx_hit;
   logic tx_cond;
   logic [3:0] err_bits;
   logic line_pend, tx_pend, modem_pend;
   logic [3:0] pend_en;
   logic [DATA_W-1:0] isr_val;
   logic [DATA_W-1:0] lsr_val;
   logic isr_txe_shown;

   if (TRIG_LVL0 == 5'h00 || int'(TRIG_LVL3) > FIFO_DEPTH) begin : g_bad_trig
      $error("uid_top: trigger levels must lie from 1 to the FIFO depth");
   end

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   assign wr_data = bus.wr && bus.addr == OFS_DATA;
   assign rd_data_reg = bus.rd && bus.addr == OFS_DATA;
   assign wr_mask = bus.wr && bus.addr == OFS_MASK;
   assign wr_fctl = bus.wr && bus.addr == OFS_FCTL;
   assign rd_fctl = bus.rd && bus.addr == OFS_FCTL;
   assign rd_lstat = bus.rd && bus.addr == OFS_LSTAT;
   assign rd_modem = bus.rd && bus.addr == OFS_MODEM;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mask_ff <= MASK_RST; // R01 R02 R03 R04
      end else if (wr_mask) begin
         mask_ff <= bus.wdata[3:0];
      end
   end

   // FIFO control; reset bits self-clear as they are never stored
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fifo_en_ff <= FCTL_RST[FCTL_EN];
         dma_mode_ff <= FCTL_RST[FCTL_DMA];
         trig_sel_ff <= FCTL_RST[FCTL_TRIG+:2];
      end else if (wr_fctl) begin
         fifo_en_ff <= bus.wdata[FCTL_EN]; // R18
         dma_mode_ff <= bus.wdata[FCTL_DMA];
         trig_sel_ff <= bus.wdata[FCTL_TRIG+:2]; // R19
      end
   end

   // Toggling FIFO mode flushes both, so stale depth never survives
   assign rx_flush = wr_fctl && (bus.wdata[FCTL_RXRST] || bus.wdata[FCTL_EN] != fifo_en_ff);
   assign tx_flush = wr_fctl && (bus.wdata[FCTL_TXRST] || bus.wdata[FCTL_EN] != fifo_en_ff);
   assign limit = fifo_en_ff ? CNT_W'(FIFO_DEPTH) : 5'h01; // R18
   assign mode1 = fifo_en_ff && dma_mode_ff;

   always_comb begin
      unique case (trig_sel_ff) // R19
         2'h0: trig = TRIG_LVL0;
         2'h1: trig = TRIG_LVL1;
         2'h2: trig = TRIG_LVL2;
         2'h3: trig = TRIG_LVL3;
      endcase
   end

   // ----------------------------------------
   // FIFO fill tracking
   // ----------------------------------------
   uid_fill_cnt #(.DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_fill (
      .core_clk(core_clk),
      .rstn(rstn),
      .push(core.rx_push), // R15
      .push_tag(|core.rx_char_err),
      .pop(rd_data_reg),
      .flush(rx_flush),
      .limit(limit),
      .count(rx_cnt),
      .full(rx_full),
      .empty(rx_empty),
      .tag_any(rx_err_any)
   );

   uid_fill_cnt #(.DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_tx_fill (
      .core_clk(core_clk),
      .rstn(rstn),
      .push(wr_data),
      .push_tag(1'b0),
      .pop(core.tx_pop),
      .flush(tx_flush),
      .limit(limit),
      .count(tx_cnt),
      .full(tx_full),
      .empty(tx_empty),
      .tag_any()
   );

   // ----------------------------------------
   // Pending sources
   // ----------------------------------------
   // Overrun: a character that finds the FIFO full is lost
   uid_sticky #(.W(4)) u_err (
      .core_clk(core_clk),
      .rstn(rstn),
      .set({core.rx_char_err & {3{core.rx_push}}, core.rx_push & rx_full}), // R08
      .clr({4{rd_lstat}}),
      .q(err_bits)
   );

   uid_sticky #(.W(1)) u_line (
      .core_clk(core_clk),
      .rstn(rstn),
      .set(core.rx_push), // R02
      .clr(rd_lstat),
      .q(line_pend)
   );

   uid_sticky #(.W(1)) u_modem (
      .core_clk(core_clk),
      .rstn(rstn),
      .set(core.modem_change), // R01
      .clr(rd_modem),
      .q(modem_pend)
   );

   // Mode 1 waits for a fully empty FIFO; otherwise any free slot counts
   assign tx_cond = mode1 ? tx_empty : ~tx_full; // R03 R14

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_cond_ff <= 1'b0;
      end else begin
         tx_cond_ff <= tx_cond;
      end
   end

   uid_sticky #(.W(1)) u_txe (
      .core_clk(core_clk),
      .rstn(rstn),
      .set(tx_cond & ~tx_cond_ff), // R03 R14
      .clr(wr_data | (rd_fctl & isr_txe_shown)),
      .q(tx_pend)
   );

   // Level source: follows fill, no clear needed
   assign rx_hit = fifo_en_ff ? (rx_cnt >= trig) : ~rx_empty; // R04 R05 R15

   assign pend_en = {modem_pend & mask_ff[MASK_MODEM], // R01
                     line_pend & mask_ff[MASK_LINE], // R02
                     tx_pend & mask_ff[MASK_TXE], // R03
                     rx_hit & mask_ff[MASK_RXD]}; // R04

   // ----------------------------------------
   // Source and line status values
   // ----------------------------------------
   always_comb begin
      isr_val = {{2{fifo_en_ff}}, 2'h0, 3'h0, 1'b1};
      isr_txe_shown = 1'b0;
      if (pend_en[MASK_LINE]) begin
         isr_val[3:0] = {SRC_LINE, 1'b0};
      end else if (pend_en[MASK_RXD]) begin
         isr_val[3:0] = {SRC_RXD, 1'b0}; // R05
      end else if (pend_en[MASK_TXE]) begin
         isr_val[3:0] = {SRC_TXE, 1'b0};
         isr_txe_shown = 1'b1;
      end else if (pend_en[MASK_MODEM]) begin
         isr_val[3:0] = {SRC_MODEM, 1'b0};
      end
   end

   // Polled use reads these bits alone, with every mask bit clear
   always_comb begin
      lsr_val = 8'h00; // R07
      lsr_val[LS_DR] = ~rx_empty; // R06
      lsr_val[LS_ERR+:4] = err_bits; // R08
      lsr_val[LS_THRE] = tx_empty; // R09
      lsr_val[LS_TEMT] = tx_empty & ~core.tx_shift_busy; // R10
      lsr_val[LS_FERR] = fifo_en_ff & rx_err_any; // R11
   end

   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_ff <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            OFS_DATA: rd_data_ff <= core.rx_data;
            OFS_MASK: rd_data_ff <= {4'h0, mask_ff};
            OFS_FCTL: rd_data_ff <= isr_val;
            OFS_LSTAT: rd_data_ff <= lsr_val;
            OFS_MODEM: rd_data_ff <= core.modem_status;
            default: rd_data_ff <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_load_ff <= 1'b0;
         tx_data_ff <= 8'h00;
         rx_take_ff <= 1'b0;
      end else begin
         tx_load_ff <= wr_data & ~tx_full;
         rx_take_ff <= rd_data_reg & ~rx_empty;
         if (wr_data) begin
            tx_data_ff <= bus.wdata;
         end
      end
   end

   // ----------------------------------------
   // Interrupt pin
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |pend_en; // R17 R20
      end
   end

   // ----------------------------------------
   // DMA request pins, active low
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_hold_ff <= 1'b0;
         tx_go_ff <= 1'b1;
      end else begin
         if (rx_empty || !mode1) begin
            rx_hold_ff <= 1'b0;
         end else if (rx_cnt >= trig) begin
            rx_hold_ff <= 1'b1; // R16
         end
         if (tx_empty) begin
            tx_go_ff <= 1'b1;
         end else if (tx_full) begin
            tx_go_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_req_n_ff <= 1'b1;
         tx_req_n_ff <= 1'b0;
      end else begin
         rx_req_n_ff <= mode1 ? ~(rx_hold_ff | rx_hit) : rx_empty; // R13 R16
         tx_req_n_ff <= mode1 ? ~tx_go_ff : tx_full; // R12
      end
   end

   assign rd_data = rd_data_ff;
   assign irq = irq_ff;
   assign rx_dma_request_n = rx_req_n_ff;
   assign tx_dma_request_n = tx_req_n_ff;
   assign tx_load = tx_load_ff;
   assign tx_load_data = tx_data_ff;
   assign rx_take = rx_take_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_irq_raise: assert property (@(posedge core_clk) disable iff (!rstn) (|pend_en) |=> irq) // R17
      else $error("irq not raised for enabled pending source");
   a_irq_drop: assert property (@(posedge core_clk) disable iff (!rstn) !(|pend_en) |=> !irq) // R20
      else $error("irq held with no enabled source");
   a_mask_write: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_mask |=> mask_ff == $past(bus.wdata[3:0])) // R01
      else $error("mask register did not take write");
   a_rx_trigger: assert property (@(posedge core_clk) disable iff (!rstn)
      (fifo_en_ff && mask_ff[MASK_RXD] && rx_cnt < trig) |-> !pend_en[MASK_RXD]) // R05
      else $error("receive source pending below trigger");
   a_data_ready: assert property (@(posedge core_clk) disable iff (!rstn)
      core.rx_push && !rx_full && !rx_flush |=> lsr_val[LS_DR]) // R06
      else $error("data ready not set after push");
   a_temt_both: assert property (@(posedge core_clk) disable iff (!rstn)
      lsr_val[LS_TEMT] |-> (tx_cnt == 5'h00 && !core.tx_shift_busy)) // R10
      else $error("transmit empty shown while busy");
   a_rx_mode0: assert property (@(posedge core_clk) disable iff (!rstn)
      !mode1 |=> rx_dma_request_n == $past(rx_empty)) // R13
      else $error("receive request wrong in mode 0");
   a_rx_mode1: assert property (@(posedge core_clk) disable iff (!rstn)
      mode1 && rx_cnt > trig |=> !rx_dma_request_n) // R16
      else $error("receive request high above trigger in mode 1");
   a_tx_mode0: assert property (@(posedge core_clk) disable iff (!rstn)
      !mode1 |=> tx_dma_request_n == $past(tx_full)) // R12
      else $error("transmit request wrong in mode 0");
   a_tx_block: assert property (@(posedge core_clk) disable iff (!rstn)
      mode1 && !tx_pend && !tx_cond_ff && tx_cnt != 5'h00 |=> !tx_pend) // R14
      else $error("transmit source set with FIFO not empty");
   a_err_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      core.rx_push && rx_full |=> err_bits[0]) // R08
      else $error("overrun not flagged");
endmodule

// file: uid_core_model.sv
// Partner model of the UART core: receive queue and a stallable transmit shifter
module uid_core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Bench controls
   input wire logic push,
   input wire logic [2:0] perr,
   input wire logic [7:0] pdata,
   input wire logic mchg,
   input wire logic drain,
   // Block side
   input wire logic tx_load,
   input wire logic rx_take,
   output uid_pkg::uid_core_s core
);
   import uid_pkg::*;
   logic [7:0] q [$];
   logic [7:0] last = 8'h00;
   logic [7:0] head_ff = 8'hff;
   int tx_q;
   logic pop_ff;
   logic [2:0] busy_ff;
   // ----------------------------------------
   // Transmit shifter
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_q <= 0;
         pop_ff <= 1'b0;
         busy_ff <= 3'h0;
      end else begin
         // Slow shifter, so the FIFO really fills against the bus
         pop_ff <= drain && tx_q > 0 && busy_ff == 3'h0 && !pop_ff;
         busy_ff <= pop_ff ? 3'h4 : (busy_ff == 3'h0 ? 3'h0 : busy_ff - 3'h1);
         tx_q <= tx_q + int'(tx_load) - int'(pop_ff);
      end
   end
   // ----------------------------------------
   // Receive holding data
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (push)
         q.push_back(pdata);
      if (rx_take && q.size() > 0)
         last = q.pop_front();
      head_ff <= q.size() > 0 ? q[0] : ~last;
   end
   // Empty head shows a changing value, never the stale byte
   always_comb begin
      core.rx_push = push;
      core.rx_char_err = perr;
      core.rx_data = head_ff;
      core.tx_pop = pop_ff;
      core.tx_shift_busy = pop_ff || busy_ff != 3'h0;
      core.modem_change = mchg;
      core.modem_status = 8'ha5;
   end
endmodule

// file: testbench.sv
// Self-checking bench of the UART interrupt enable, line status and DMA-ready block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import uid_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   uid_bus_s bus = '0;
   uid_core_s core;
   logic [7:0] rd_data;
   logic [7:0] pdata = 8'h00;
   logic [7:0] got;
   logic [7:0] tx_ld;
   logic [7:0] v;
   logic [2:0] perr = 3'h0;
   logic push = 1'b0;
   logic mchg = 1'b0;
   logic drain = 1'b0;
   logic tx_load, rx_take, irq, rx_n, tx_n;
   logic [7:0] rxq [$];
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   int seed = 32'hf2b0;
   int trig [4] = '{1, 4, 8, 14};

   always #20 core_clk = ~core_clk;

   uid_top u_uid_top (.core_clk(core_clk), .rstn(rstn), .bus(bus), .rd_data(rd_data), .core(core),
      .tx_load(tx_load), .tx_load_data(tx_ld), .rx_take(rx_take), .irq(irq), .rx_dma_request_n(rx_n),
      .tx_dma_request_n(tx_n));
   uid_core_model u_uid_core_model (.core_clk(core_clk), .rstn(rstn), .push(push), .perr(perr),
      .pdata(pdata), .mchg(mchg), .drain(drain), .tx_load(tx_load), .rx_take(rx_take), .core(core));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      tick();
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      tick();
      bus <= '0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      tick();
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      tick();
      bus <= '0;
      #1 d = rd_data;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      rd(a, got);
      chk(got, e);
   endtask
   task automatic rdat();
      rd(OFS_DATA, got);
      chk(got, rxq.pop_front());
   endtask
   // Pins are registered up to three deep behind the strobes
   task automatic pins(input logic ei, input logic er, input logic et);
      tick(4);
      #1;
      chk({5'h0, irq, rx_n, tx_n}, {5'h0, ei, er, et});
   endtask
   task automatic rx_char(input logic [2:0] e);
      tick();
      v = 8'($random(seed));
      rxq.push_back(v);
      push <= 1'b1;
      perr <= e;
      pdata <= v;
      tick();
      push <= 1'b0;
      perr <= 3'h0;
   endtask
   task automatic wait_ls(input int b);
      got = 8'h00;
      for (int k = 0; k < 300 && got[b] !== 1'b1; k++)
         rd(OFS_LSTAT, got);
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      tick(12);
      rstn <= 1'b1;
      pins(1'b0, 1'b1, 1'b0);
      rchk(OFS_MASK, 8'h00);
      rchk(OFS_LSTAT, LSR_RST);
      rchk(OFS_FCTL, ISR_RST);
      rchk(3'h7, 8'h00);
      v = 8'($random(seed));
      wr(OFS_MASK, v);
      rchk(OFS_MASK, v & 8'h0f);
      wr(OFS_MASK, 8'h00);
      $display("test reset done");
      wr(OFS_FCTL, 8'h07);
      repeat (3) rx_char(3'h0);
      pins(1'b0, 1'b0, 1'b0);
      rchk(OFS_LSTAT, 8'h61);
      rchk(OFS_FCTL, 8'hc1);
      repeat (3) rdat();
      rchk(OFS_LSTAT, 8'h60);
      pins(1'b0, 1'b1, 1'b0);
      wr(OFS_FCTL, 8'h00);
      rx_char(3'h0);
      pins(1'b0, 1'b0, 1'b0);
      rchk(OFS_FCTL, 8'h01);
      rdat();
      $display("test polled done");
      for (int i = 0; i < 4; i++) begin
         wr(OFS_FCTL, 8'(i << 6) | 8'h0f);
         wr(OFS_MASK, 8'h01);
         repeat (trig[i] - 1) rx_char(3'h0);
         pins(1'b0, 1'b1, 1'b0);
         rx_char(3'h0);
         pins(1'b1, 1'b0, 1'b0);
         rchk(OFS_FCTL, {2'h3, 2'h0, SRC_RXD, 1'b0});
         if (i == 3) begin
            repeat (2) rx_char(3'h0);
            rchk(OFS_LSTAT, 8'h61);
            repeat (2) rdat();
         end
         rdat();
         pins(1'b0, trig[i] == 1, 1'b0);
         while (rxq.size() > 0)
            rdat();
         pins(1'b0, 1'b1, 1'b0);
      end
      $display("test trigger done");
      wr(OFS_FCTL, 8'h07);
      wr(OFS_MASK, 8'h04);
      for (int e = 0; e < 3; e++) begin
         rx_char(3'(1 << e));
         pins(1'b1, 1'b0, 1'b0);
         rchk(OFS_LSTAT, 8'he1 | 8'(8'h04 << e));
         pins(1'b0, 1'b0, 1'b0);
         rdat();
      end
      // Flush with data waiting; the partner keeps its copy, unread from here on
      repeat (2) rx_char(3'h0);
      wr(OFS_FCTL, 8'h03);
      rchk(OFS_LSTAT, 8'h60);
      rxq.delete();
      $display("test line done");
      wr(OFS_MASK, 8'h00);
      tick();
      mchg <= 1'b1;
      tick();
      mchg <= 1'b0;
      pins(1'b0, 1'b1, 1'b0);
      wr(OFS_MASK, 8'h08);
      pins(1'b1, 1'b1, 1'b0);
      rchk(OFS_MODEM, 8'ha5);
      pins(1'b0, 1'b1, 1'b0);
      $display("test modem done");
      wr(OFS_MASK, 8'h02);
      repeat (16) wr(OFS_DATA, 8'($random(seed)));
      rchk(OFS_LSTAT, 8'h00);
      pins(1'b0, 1'b1, 1'b1);
      drain <= 1'b1;
      wait_ls(6);
      chk(got, 8'h60);
      pins(1'b1, 1'b1, 1'b0);
      rchk(OFS_FCTL, {2'h3, 2'h0, SRC_TXE, 1'b0});
      pins(1'b0, 1'b1, 1'b0);
      wr(OFS_FCTL, 8'h0f);
      repeat (2) begin
         v = 8'($random(seed));
         wr(OFS_DATA, v);
      end
      #1 chk(tx_ld, v);
      wait_ls(5);
      pins(1'b1, 1'b1, 1'b0);
      $display("test transmit done");
      results();
   end
endmodule
